//--- core/scp_defs.svh
// Constants for the serial comm port programming block
// Behaviour
// - A write to port 17h re-enables the port interrupts; data ignored.
// - A write to port 15h loads the holding register and drops holding-free.
// - Short characters are right-justified; only the low-order bits are sent.
// - After any reset the first byte to port 35h is the mode word.
// - Async mode: every following byte to port 35h is a command word.
// - Sync mode: next one or two bytes are sync pattern, then commands.
// - Async mode bits 7:6 pick stop bits: invalid, 1, 1.5 or 2.
// - Mode bit 5 picks even parity when set, odd parity when clear.
// - Mode bit 4 enables parity generation and checking.
// - Mode bits 3:2 set character length five to eight bits.
// - Mode bits 1:0 pick sync, times one, sixteen or sixty-four.
// - Sync mode bit 7 picks single sync character, clear picks double.
// - Command bit 7 enters hunt mode, only in synchronous operation.
// - Command bit 6 resets the transceiver back to expecting a mode word.
// - Command bit 5 drives the active-low request-to-send pin low.
// - Command bit 4 clears framing, overrun and parity error flags.
// - Command bit 3 holds the line in break until a command clears it.
// - Command bit 2 enables the receiver, clear disables reception.
// - Command bit 1 drives the active-low data-terminal-ready pin low.
// - Command bit 0 enables the transmitter, clear disables it.
// - A write to port 16h disables the interrupts; also off after reset.
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_PORT_TXDATA 8'h15
`define SCP_PORT_IRQ_OFF 8'h16
`define SCP_PORT_IRQ_ON 8'h17
`define SCP_PORT_MODECMD 8'h35
`define SCP_MODE_RST 8'h00
`define SCP_CMD_RST 8'h00
`define SCP_MODE_SINGLE 7
`define SCP_MODE_EVEN 5
`define SCP_MODE_PEN 4
`define SCP_CMD_HUNT 7
`define SCP_CMD_IRST 6
`define SCP_CMD_RTS 5
`define SCP_CMD_ERST 4
`define SCP_CMD_BREAK 3
`define SCP_CMD_RXEN 2
`define SCP_CMD_DTR 1
`define SCP_CMD_TXEN 0
`define SCP_FAC_SYNC 2'h0
`define SCP_FAC_X1 2'h1
`define SCP_FAC_X16 2'h2
`define SCP_STOP_ONE_HALF 2'h2
`define SCP_STOP_TWO 2'h3
`define SCP_TICKS_X1 8'h01
`define SCP_TICKS_X16 8'h10
`define SCP_TICKS_X64 8'h40
`define SCP_STATUS_TXFREE 0
`define SCP_STATUS_RXWAIT 1
`define SCP_STATUS_TXEMPTY 2
`define SCP_STATUS_PERR 3
`define SCP_STATUS_OERR 4
`define SCP_STATUS_FERR 5
`define SCP_STATUS_SYNDET 6
`define SCP_STATUS_TRANSCEIVER_CLKS 28
`endif

//--- core/scp_pkg.sv
// Types and shared decode functions of the serial comm port block
`include "scp_defs.svh"
package scp_pkg;
  typedef enum logic [1:0] {SEQ_MODE, SEQ_SYNC1, SEQ_SYNC2, SEQ_CMD} scp_seq_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    scp_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP,
    RX_HUNT} scp_rx_e;

  // Character length minus one, five to eight bits
  function automatic logic [2:0] scp_last_bit(input logic [7:0] mode);
    scp_last_bit = 3'h4 + {1'b0, mode[3:2]};
  endfunction

  function automatic logic [7:0] scp_len_mask(input logic [7:0] mode);
    scp_len_mask = 8'hff >> (3'h7 - scp_last_bit(mode));
  endfunction

  // Parity bit that goes with a character under the current mode
  function automatic logic scp_parity(input logic [7:0] mode,
    input logic [7:0] data);
    scp_parity = (^(data & scp_len_mask(mode))) ^ ~mode[`SCP_MODE_EVEN];
  endfunction

  // Link clocks per bit for the selected clock factor
  function automatic logic [7:0] scp_bit_ticks(input logic [7:0] mode);
    unique case (mode[1:0])
      `SCP_FAC_SYNC, `SCP_FAC_X1: scp_bit_ticks = `SCP_TICKS_X1;
      `SCP_FAC_X16: scp_bit_ticks = `SCP_TICKS_X16;
      default: scp_bit_ticks = `SCP_TICKS_X64;
    endcase
  endfunction
endpackage

//--- core/scp_sync2.sv
// Two-flop synchroniser for quasi-static levels and toggles
module scp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } scp_sync_s;

  scp_sync_s s_r;
  scp_sync_s s_nxt;

  always_comb
  begin
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;
endmodule

//--- core/scp_port.sv
// Serial comm port: host port decode, sequencing and transceiver link side
`include "scp_defs.svh"
module scp_port
  import scp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic xcvr_clk,
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic tc_irq_en,
  output logic tx_irq,
  output logic rx_irq
);
  typedef struct packed {
    scp_seq_e seq;
    logic [7:0] mode;
    logic [7:0] cmd;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] thr;
    logic thr_full;
    logic [7:0] txsh;
    logic tx_req;
    logic hunt_tgl;
    logic irq_en;
    logic [7:0] rx_buf;
    logic rx_full;
    logic pe;
    logic oe;
    logic fe;
    logic rx_seen;
    logic [7:0] rdata;
  } scp_host_s;

  typedef struct packed {
    scp_tx_e tx_st;
    logic [7:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_ack;
    logic txd;
    scp_rx_e rx_st;
    logic [7:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    logic rx_tgl;
    logic hunt_seen;
    logic hunt2;
    logic sync_det;
  } scp_link_s;

  scp_host_s h_r;
  scp_host_s h_nxt;
  scp_link_s l_r;
  scp_link_s l_nxt;

  logic [2:0] host_in;
  logic tx_ack_s;
  logic rx_tgl_s;
  logic sync_det_s;
  logic [18:0] link_in;
  logic [7:0] mode_s;
  logic [7:0] cmd_s;
  logic tx_req_s;
  logic hunt_s;
  logic rxd_s;

  // Link toward host: toggles and one level
  scp_sync2 #(.W(3)) u_to_host (
    .clk(ref_clk),
    .rst(rst),
    .d({l_r.tx_ack, l_r.rx_tgl, l_r.sync_det}),
    .q(host_in)
  );
  assign {tx_ack_s, rx_tgl_s, sync_det_s} = host_in;

  // Mode and command are set up while the line is idle, so per-bit skew
  // on their crossing does no harm
  scp_sync2 #(.W(19)) u_to_link (
    .clk(xcvr_clk),
    .rst(rst),
    .d({h_r.mode, h_r.cmd, h_r.tx_req, h_r.hunt_tgl, rxd_pin}),
    .q(link_in)
  );
  assign {mode_s, cmd_s, tx_req_s, hunt_s, rxd_s} = link_in;

  // Host side
  always_comb
  begin
    logic sync_mode;
    logic [7:0] status;
    sync_mode = (h_r.mode[1:0] == `SCP_FAC_SYNC);
    status = 8'h00;
    status[`SCP_STATUS_TXFREE] = ~h_r.thr_full;
    status[`SCP_STATUS_RXWAIT] = h_r.rx_full;
    status[`SCP_STATUS_TXEMPTY] = ~h_r.thr_full & (h_r.tx_req == tx_ack_s);
    status[`SCP_STATUS_PERR] = h_r.pe;
    status[`SCP_STATUS_OERR] = h_r.oe;
    status[`SCP_STATUS_FERR] = h_r.fe;
    status[`SCP_STATUS_SYNDET] = sync_det_s;
    h_nxt = h_r;
    // Hand the held character to the link once the last one was taken
    if (h_r.thr_full && (h_r.tx_req == tx_ack_s))
    begin
      h_nxt.txsh = h_r.thr;
      h_nxt.tx_req = ~h_r.tx_req;
      h_nxt.thr_full = 1'b0;
    end
    if (io_rd)
    begin
      if (io_addr == `SCP_PORT_TXDATA)
      begin
        h_nxt.rdata = h_r.rx_buf;
        h_nxt.rx_full = 1'b0;
      end
      else if (io_addr == `SCP_PORT_MODECMD)
      begin
        h_nxt.rdata = status;
      end
      else
      begin
        h_nxt.rdata = 8'h00;
      end
    end
    if (io_wr)
    begin
      if (io_addr == `SCP_PORT_IRQ_ON)
      begin
        h_nxt.irq_en = 1'b1;
      end
      else if (io_addr == `SCP_PORT_IRQ_OFF)
      begin
        h_nxt.irq_en = 1'b0;
      end
      else if (io_addr == `SCP_PORT_TXDATA)
      begin
        h_nxt.thr = io_wdata & scp_len_mask(h_r.mode);
        h_nxt.thr_full = 1'b1;
      end
      else if (io_addr == `SCP_PORT_MODECMD)
      begin
        unique case (h_r.seq)
          SEQ_MODE:
          begin
            h_nxt.mode = io_wdata;
            h_nxt.seq = (io_wdata[1:0] == `SCP_FAC_SYNC) ? SEQ_SYNC1 :
              SEQ_CMD;
          end
          SEQ_SYNC1:
          begin
            h_nxt.sync1 = io_wdata;
            h_nxt.seq = h_r.mode[`SCP_MODE_SINGLE] ? SEQ_CMD :
              SEQ_SYNC2;
          end
          SEQ_SYNC2:
          begin
            h_nxt.sync2 = io_wdata;
            h_nxt.seq = SEQ_CMD;
          end
          SEQ_CMD:
          begin
            if (io_wdata[`SCP_CMD_IRST])
            begin
              h_nxt.seq = SEQ_MODE;
              h_nxt.cmd = `SCP_CMD_RST;
              h_nxt.thr_full = 1'b0;
              h_nxt.rx_full = 1'b0;
              h_nxt.pe = 1'b0;
              h_nxt.oe = 1'b0;
              h_nxt.fe = 1'b0;
            end
            else
            begin
              h_nxt.cmd = io_wdata;
              if (io_wdata[`SCP_CMD_ERST])
              begin
                h_nxt.pe = 1'b0;
                h_nxt.oe = 1'b0;
                h_nxt.fe = 1'b0;
              end
              if (io_wdata[`SCP_CMD_HUNT] && sync_mode)
              begin
                h_nxt.hunt_tgl = ~h_r.hunt_tgl;
              end
            end
          end
        endcase
      end
    end
    // A character arriving with a clear still wins over the clear
    if (rx_tgl_s != h_r.rx_seen)
    begin
      h_nxt.rx_seen = rx_tgl_s;
      h_nxt.rx_buf = l_r.rx_data;
      // A read in the same cycle frees the buffer, so no overrun then
      h_nxt.oe = h_nxt.oe | h_nxt.rx_full;
      h_nxt.rx_full = 1'b1;
      h_nxt.pe = h_nxt.pe | l_r.rx_perr;
      h_nxt.fe = h_nxt.fe | l_r.rx_ferr;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      h_r <= '0;
      h_r.seq <= SEQ_MODE;
      h_r.mode <= `SCP_MODE_RST;
      h_r.cmd <= `SCP_CMD_RST;
      h_r.irq_en <= 1'b0;
    end
    else
    begin
      h_r <= h_nxt;
    end
  end

  // Link side, on the transceiver clock
  always_comb
  begin
    logic sync_mode;
    logic [7:0] ticks;
    logic [2:0] last;
    logic line;
    logic [7:0] win;
    logic [7:0] chr;
    sync_mode = (mode_s[1:0] == `SCP_FAC_SYNC);
    ticks = scp_bit_ticks(mode_s);
    last = scp_last_bit(mode_s);
    line = l_r.txd;
    win = {rxd_s, l_r.rx_sh[7:1]};
    chr = win >> (3'h7 - last);
    l_nxt = l_r;
    l_nxt.tx_cnt = l_r.tx_cnt - 8'h01;
    l_nxt.rx_cnt = l_r.rx_cnt - 8'h01;
    unique case (l_r.tx_st)
      TX_IDLE:
      begin
        line = 1'b1;
        l_nxt.tx_cnt = ticks - 8'h01;
        l_nxt.tx_bit = 3'h0;
        if ((tx_req_s != l_r.tx_ack) && cmd_s[`SCP_CMD_TXEN])
        begin
          l_nxt.tx_sh = h_r.txsh;
          l_nxt.tx_ack = tx_req_s;
          l_nxt.tx_st = sync_mode ? TX_DATA : TX_START;
          line = sync_mode ? h_r.txsh[0] : 1'b0;
        end
      end
      TX_START:
      begin
        if (l_r.tx_cnt == 8'h00)
        begin
          l_nxt.tx_cnt = ticks - 8'h01;
          l_nxt.tx_st = TX_DATA;
          line = l_r.tx_sh[0];
        end
      end
      TX_DATA:
      begin
        if (l_r.tx_cnt == 8'h00)
        begin
          l_nxt.tx_cnt = ticks - 8'h01;
          l_nxt.tx_bit = l_r.tx_bit + 3'h1;
          line = l_r.tx_sh[l_r.tx_bit + 3'h1];
          if (l_r.tx_bit == last)
          begin
            if (mode_s[`SCP_MODE_PEN])
            begin
              l_nxt.tx_st = TX_PAR;
              line = scp_parity(mode_s, l_r.tx_sh);
            end
            else
            begin
              l_nxt.tx_st = sync_mode ? TX_IDLE : TX_STOP;
              line = 1'b1;
            end
          end
        end
      end
      TX_PAR:
      begin
        if (l_r.tx_cnt == 8'h00)
        begin
          l_nxt.tx_st = sync_mode ? TX_IDLE : TX_STOP;
          line = 1'b1;
        end
      end
      TX_STOP:
      begin
        if (l_r.tx_cnt == 8'h00)
        begin
          l_nxt.tx_st = TX_IDLE;
        end
      end
      default:
      begin
        l_nxt.tx_st = TX_IDLE;
      end
    endcase
    // Stop length is loaded as the line goes to mark after the last bit
    if ((l_nxt.tx_st == TX_STOP) && (l_r.tx_st != TX_STOP))
    begin
      unique case (mode_s[7:6])
        `SCP_STOP_ONE_HALF:
          l_nxt.tx_cnt = ticks + (ticks >> 1) - 8'h01;
        `SCP_STOP_TWO: l_nxt.tx_cnt = (ticks << 1) - 8'h01;
        default: l_nxt.tx_cnt = ticks - 8'h01;
      endcase
    end
    l_nxt.txd = line & ~cmd_s[`SCP_CMD_BREAK];

    unique case (l_r.rx_st)
      RX_IDLE:
      begin
        l_nxt.rx_bit = 3'h0;
        if (cmd_s[`SCP_CMD_RXEN] && sync_mode && l_r.sync_det)
        begin
          l_nxt.rx_st = RX_DATA;
          l_nxt.rx_cnt = 8'h00;
        end
        else if (cmd_s[`SCP_CMD_RXEN] && !sync_mode && !rxd_s)
        begin
          l_nxt.rx_st = RX_START;
          l_nxt.rx_cnt = ticks >> 1;
        end
      end
      RX_START:
      begin
        if (l_r.rx_cnt == 8'h00)
        begin
          l_nxt.rx_cnt = ticks - 8'h01;
          l_nxt.rx_st = rxd_s ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (l_r.rx_cnt == 8'h00)
        begin
          l_nxt.rx_cnt = ticks - 8'h01;
          l_nxt.rx_sh[l_r.rx_bit] = rxd_s;
          l_nxt.rx_bit = l_r.rx_bit + 3'h1;
          if (l_r.rx_bit == last)
          begin
            l_nxt.rx_bit = 3'h0;
            l_nxt.rx_perr = 1'b0;
            l_nxt.rx_ferr = 1'b0;
            if (mode_s[`SCP_MODE_PEN])
            begin
              l_nxt.rx_st = RX_PAR;
            end
            else if (!sync_mode)
            begin
              l_nxt.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_PAR:
      begin
        if (l_r.rx_cnt == 8'h00)
        begin
          l_nxt.rx_cnt = ticks - 8'h01;
          l_nxt.rx_perr = rxd_s ^ scp_parity(mode_s, l_r.rx_sh);
          l_nxt.rx_st = sync_mode ? RX_DATA : RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (l_r.rx_cnt == 8'h00)
        begin
          l_nxt.rx_ferr = ~rxd_s;
          l_nxt.rx_st = RX_IDLE;
        end
      end
      RX_HUNT:
      begin
        // Slide a window one bit per clock until the pattern lines up
        l_nxt.rx_sh = win;
        if (!l_r.hunt2 && (chr == (h_r.sync1 & scp_len_mask(mode_s))))
        begin
          l_nxt.rx_sh = 8'h00;
          if (mode_s[`SCP_MODE_SINGLE])
          begin
            l_nxt.sync_det = 1'b1;
            l_nxt.rx_st = RX_IDLE;
          end
          else
          begin
            l_nxt.hunt2 = 1'b1;
            l_nxt.rx_bit = 3'h0;
          end
        end
        else if (l_r.hunt2)
        begin
          l_nxt.rx_sh = l_r.rx_sh;
          l_nxt.rx_sh[l_r.rx_bit] = rxd_s;
          l_nxt.rx_bit = l_r.rx_bit + 3'h1;
          if (l_r.rx_bit == last)
          begin
            l_nxt.hunt2 = 1'b0;
            if ((l_nxt.rx_sh & scp_len_mask(mode_s)) ==
              (h_r.sync2 & scp_len_mask(mode_s)))
            begin
              l_nxt.sync_det = 1'b1;
              l_nxt.rx_st = RX_IDLE;
            end
          end
        end
      end
      default:
      begin
        l_nxt.rx_st = RX_IDLE;
      end
    endcase
    // Deliver a finished character to the host domain
    if (((l_r.rx_st == RX_STOP) || (l_r.rx_st == RX_PAR && sync_mode) ||
      (l_r.rx_st == RX_DATA && sync_mode && !mode_s[`SCP_MODE_PEN] &&
      l_r.rx_bit == last)) && (l_r.rx_cnt == 8'h00))
    begin
      l_nxt.rx_data = l_nxt.rx_sh & scp_len_mask(mode_s);
      l_nxt.rx_tgl = ~l_r.rx_tgl;
    end
    if (!cmd_s[`SCP_CMD_RXEN] && l_r.rx_st != RX_HUNT)
    begin
      l_nxt.rx_st = RX_IDLE;
    end
    if (hunt_s != l_r.hunt_seen)
    begin
      l_nxt.hunt_seen = hunt_s;
      l_nxt.rx_st = RX_HUNT;
      l_nxt.hunt2 = 1'b0;
      l_nxt.sync_det = 1'b0;
    end
    if (!sync_mode)
    begin
      l_nxt.sync_det = 1'b0;
    end
  end

  always_ff @(posedge xcvr_clk or posedge rst)
  begin
    if (rst)
    begin
      l_r <= '0;
      l_r.txd <= 1'b1;
      l_r.tx_st <= TX_IDLE;
      l_r.rx_st <= RX_IDLE;
    end
    else
    begin
      l_r <= l_nxt;
    end
  end

  assign io_rdata = h_r.rdata;
  assign txd_pin = l_r.txd;
  assign rts_n = ~h_r.cmd[`SCP_CMD_RTS];
  assign dtr_n = ~h_r.cmd[`SCP_CMD_DTR];
  assign tc_irq_en = h_r.irq_en;
  assign tx_irq = h_r.irq_en & ~h_r.thr_full;
  assign rx_irq = h_r.irq_en & h_r.rx_full;
endmodule

//--- test/scp_port_checker.sv
// Port-level assertions of the serial comm port block
module scp_port_checker
  import scp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic txd_pin,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic tc_irq_en,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Shadow sequencer, so command bytes can be told from mode and sync
  logic [1:0] seq_r;
  logic [1:0] seq_nxt;
  logic sngl_r;
  logic sngl_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic mwr;
  logic cmd_wr;
  assign mwr = io_wr && io_addr == 8'h35;
  assign cmd_wr = mwr && seq_r == 2'h3;
  always_comb
  begin
    seq_nxt = seq_r;
    sngl_nxt = sngl_r;
    cmd_nxt = cmd_r;
    if (mwr)
    begin
      case (seq_r)
        2'h0:
        begin
          sngl_nxt = io_wdata[7];
          seq_nxt = (io_wdata[1:0] == 2'h0) ? 2'h1 : 2'h3;
        end
        2'h1: seq_nxt = sngl_r ? 2'h3 : 2'h2;
        2'h2: seq_nxt = 2'h3;
        default:
        begin
          seq_nxt = io_wdata[6] ? 2'h0 : 2'h3;
          cmd_nxt = io_wdata[6] ? 8'h00 : io_wdata;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      seq_r <= 2'h0;
      sngl_r <= 1'b0;
      cmd_r <= 8'h00;
    end
    else
    begin
      seq_r <= seq_nxt;
      sngl_r <= sngl_nxt;
      cmd_r <= cmd_nxt;
    end
  end
  AST_IRQ_ON: assert property (io_wr && io_addr == 8'h17 |=> tc_irq_en)
    else $error("interrupt enable not set");
  AST_IRQ_OFF: assert property (io_wr && io_addr == 8'h16 |=> !tc_irq_en)
    else $error("interrupt enable not cleared");
  AST_TX_LOAD: assert property (io_wr && io_addr == 8'h15 |=> !tx_irq)
    else $error("transmit request stayed up after load");
  AST_IRQ_GATE: assert property (tx_irq || rx_irq |-> tc_irq_en)
    else $error("request raised while interrupts disabled");
  AST_RTS: assert property (cmd_wr |-> ##[1:3] rts_n == !cmd_r[5])
    else $error("request-to-send does not follow command");
  AST_DTR: assert property (cmd_wr |-> ##[1:3] dtr_n == !cmd_r[1])
    else $error("terminal-ready does not follow command");
  AST_IRST: assert property (cmd_wr && io_wdata[6] |-> ##[1:3] rts_n && dtr_n)
    else $error("modem outputs survived internal reset");
  AST_BREAK: assert property (cmd_wr && io_wdata[3] && !io_wdata[6]
    |-> ##[1:12] !txd_pin)
    else $error("break not driven on line");
  AST_SYNC_QUIET: assert property (mwr && seq_r inside {2'h1, 2'h2}
    |=> $stable(rts_n) && $stable(dtr_n))
    else $error("sync byte acted as command");
  cover property (cmd_wr && io_wdata[6]);
  cover property (mwr && seq_r == 2'h2);
  cover property (io_wr && io_addr == 8'h15);
endmodule

bind scp_port scp_port_checker chk_i (.ref_clk(ref_clk), .rst(rst),
  .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .txd_pin(txd_pin),
  .rts_n(rts_n), .dtr_n(dtr_n), .tc_irq_en(tc_irq_en), .tx_irq(tx_irq),
  .rx_irq(rx_irq));

//--- test/scp_modem.sv
// Modem model: samples the transmit line and drives the receive line
module scp_modem (
  input wire logic xcvr_clk,
  input wire logic txd_pin,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rxd_pin = 1'b1;
  // Twelve samples from the start edge, mid-bit on the falling edge
  task automatic capture(input int ticks, output logic [11:0] bits);
    @(negedge txd_pin);
    repeat ((ticks + 1) / 2) @(negedge xcvr_clk);
    bits[0] = txd_pin;
    for (int i = 1; i < 12; i++)
    begin
      repeat (ticks) @(negedge xcvr_clk);
      bits[i] = txd_pin;
    end
  endtask
  // Start bit first; the trailing ones leave the line at mark
  task automatic send(input int ticks, input logic [11:0] bits);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge xcvr_clk);
      #3 rxd_pin = bits[i];
      repeat (ticks - 1) @(posedge xcvr_clk);
    end
  endtask
endmodule

//--- test/scp_port_bench.sv
// Self-checking bench of the serial comm port block
module scp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic xcvr_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] io_addr = 8'h00;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic io_rd = 1'b0;
  logic [7:0] io_rdata;
  logic rxd_pin, txd_pin, rts_n, dtr_n, tc_irq_en, tx_irq, rx_irq;
  logic [7:0] st;
  logic [11:0] got;
  int errors = 0;
  int checked = 0;
  logic [7:0] modes [5] = '{8'hf9, 8'h41, 8'h5e, 8'h8f, 8'h0d};
  logic [7:0] chars [5] = '{8'hc5, 8'hff, 8'ha3, 8'h5a, 8'h81};

  always #25 ref_clk = ~ref_clk;
  always #32 xcvr_clk = ~xcvr_clk;

  scp_port uut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata),
    .xcvr_clk(xcvr_clk), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .rts_n(rts_n), .dtr_n(dtr_n), .tc_irq_en(tc_irq_en), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  scp_modem modem (.xcvr_clk(xcvr_clk), .txd_pin(txd_pin),
    .rxd_pin(rxd_pin));

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    io_addr = a;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  // Expected line bits: start, data LSB first, parity, then mark
  function automatic logic [11:0] frame(input logic [7:0] m,
    input logic [7:0] d);
    int len;
    logic [11:0] b;
    len = 5 + int'(m[3:2]);
    b = 12'hfff;
    b[0] = 1'b0;
    for (int i = 0; i < len; i++)
      b[i + 1] = d[i];
    if (m[4])
      b[len + 1] = ^(d & (8'hff >> (8 - len))) ^ ~m[5];
    return b;
  endfunction
  function automatic int ticks(input logic [7:0] m);
    return m[1:0] == 2'h3 ? 64 : (m[1:0] == 2'h2 ? 16 : 1);
  endfunction
  task automatic finish_test();
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #2000000;
    errors++;
    finish_test();
  end

  initial
  begin
    tick(8);
    rst = 1'b0;
    chk({10'h0, rts_n, dtr_n}, 12'h3);
    chk(12'(tc_irq_en), 12'h0);
    wr(8'h17, 8'h3c);
    chk(12'(tc_irq_en), 12'h1);
    wr(8'h16, 8'hff);
    chk(12'(tc_irq_en), 12'h0);
    wr(8'h17, 8'h00);
    // Double sync: pattern bytes shaped like commands must not act
    wr(8'h35, 8'h0c);
    wr(8'h35, 8'h22);
    wr(8'h35, 8'h22);
    tick(4);
    chk({10'h0, rts_n, dtr_n}, 12'h3);
    wr(8'h35, 8'h02);
    tick(4);
    chk({10'h0, rts_n, dtr_n}, 12'h2);
    wr(8'h35, 8'h40);
    tick(4);
    chk({10'h0, rts_n, dtr_n}, 12'h3);
    wr(8'h35, 8'h8c);
    wr(8'h35, 8'h22);
    wr(8'h35, 8'h22);
    tick(4);
    chk({10'h0, rts_n, dtr_n}, 12'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h35, 8'h40);
      wr(8'h35, modes[i]);
      wr(8'h35, 8'h04);
      wr(8'h15, chars[i]);
      chk(12'(tx_irq), 12'h0);
      tick(40);
      chk(12'(txd_pin), 12'h1);
      chk(12'(tx_irq), 12'h1);
      chk({10'h0, rts_n, dtr_n}, 12'h3);
      wr(8'h35, 8'h05);
      modem.capture(ticks(modes[i]), got);
      chk(got, frame(modes[i], chars[i]));
    end
    wr(8'h35, 8'h09);
    tick(20);
    chk(12'(txd_pin), 12'h0);
    wr(8'h35, 8'h0b);
    tick(20);
    chk(12'(txd_pin), 12'h0);
    wr(8'h35, 8'h01);
    tick(20);
    chk(12'(txd_pin), 12'h1);
    // Receive at x16; waits cover the status settling time
    wr(8'h35, 8'h40);
    wr(8'h35, 8'h5e);
    wr(8'h35, 8'h05);
    modem.send(16, frame(8'h5e, 8'h3c));
    tick(40);
    chk(12'(rx_irq), 12'h1);
    rd(8'h15, st);
    chk(12'(st), 12'h03c);
    chk(12'(rx_irq), 12'h0);
    modem.send(16, frame(8'h5e, 8'h3c) ^ 12'h200);
    tick(40);
    rd(8'h15, st);
    rd(8'h35, st);
    chk(12'(st[3]), 12'h1);
    wr(8'h35, 8'h11);
    tick(40);
    rd(8'h35, st);
    chk(12'(st[3]), 12'h0);
    modem.send(16, frame(8'h5e, 8'h3c));
    tick(40);
    chk(12'(rx_irq), 12'h0);
    // Hunt for a single sync byte; idle mark must not match
    wr(8'h35, 8'h40);
    wr(8'h35, 8'h8c);
    wr(8'h35, 8'h96);
    wr(8'h35, 8'h84);
    tick(40);
    rd(8'h35, st);
    chk(12'(st[6]), 12'h0);
    modem.send(1, 12'hf96);
    tick(40);
    rd(8'h35, st);
    chk(12'(st[6]), 12'h1);
    finish_test();
  end
endmodule
